// ---- rtl/fci_host.sv ----
`timescale 1ns/10ps
`include "fci_defs.svh"
module fci_host #(
	parameter int unsigned ERASE_CYC = `FCI_ERASE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// User request
	input wire logic req_valid,
	input fci_pkg::fci_req_t req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	// Flash pins
	output fci_pkg::fci_pins_t pins,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe
);
	import fci_pkg::*;

	fci_state_t state, next_state;
	fci_req_t cur, next_cur;
	logic [23:0] cnt, next_cnt;
	fci_pins_t next_pins;
	logic [7:0] next_dq_out, next_rsp_data;
	logic next_dq_oe, next_rsp_valid;

	// First data byte of a write pair
	function automatic logic [7:0] first_byte(input fci_req_t r);
		case (r.op)
			`FCI_OP_READ: first_byte = `FCI_CMD_READ;
			`FCI_OP_ID: first_byte = `FCI_CMD_ID;
			`FCI_OP_ERASE: first_byte = `FCI_CMD_ERASE;
			`FCI_OP_ERASE_VFY: first_byte = `FCI_CMD_ERASE_VFY;
			`FCI_OP_PROG: first_byte = `FCI_CMD_PROG;
			`FCI_OP_PROG_VFY: first_byte = `FCI_CMD_PROG_VFY;
			`FCI_OP_ABORT: first_byte = `FCI_CMD_RESET;
			default: first_byte = r.data;
		endcase
	endfunction

	// Ops that need a second write cycle
	function automatic logic two_writes(input logic [2:0] op);
		two_writes = (op == `FCI_OP_ERASE) || (op == `FCI_OP_PROG) ||
			(op == `FCI_OP_ABORT);
	endfunction

	// Ops that end with a read cycle
	function automatic logic ends_read(input logic [2:0] op);
		ends_read = (op == `FCI_OP_READ) || (op == `FCI_OP_ID) ||
			(op == `FCI_OP_ERASE_VFY) || (op == `FCI_OP_PROG_VFY);
	endfunction

	assign req_ready = (state == S_IDLE);

	// Sequencer next values
	always_comb begin
		next_state = state;
		next_cur = cur;
		next_cnt = (cnt == 24'h0) ? 24'h0 : cnt - 24'h1;
		next_pins = pins;
		next_dq_out = dq_out;
		next_dq_oe = dq_oe;
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data;
		case (state)
			S_IDLE: begin
				next_pins.cs_n = 1'b1;
				next_pins.oe_n = 1'b1;
				next_pins.we_n = 1'b1;
				next_dq_oe = 1'b0;
				if (req_valid) begin
					next_cur = req;
					next_pins.vpp_high = 1'b1;
					// Id by high voltage unused; line held low
					next_pins.id_high_voltage_address_line = 1'b0;
					// Verify write carries address on falling edge
					next_pins.addr = req.addr;
					next_pins.cs_n = 1'b0;
					next_pins.we_n = 1'b0;
					next_dq_out = first_byte(req);
					next_dq_oe = 1'b1;
					next_cnt = 24'(`FCI_PHASE_CYC - 1);
					next_state = S_W1_LO;
				end
			end
			S_W1_LO: if (cnt == 24'h0) begin
				// Rising strobe latches command
				next_pins.we_n = 1'b1;
				next_cnt = 24'(`FCI_PHASE_CYC - 1);
				next_state = S_W1_HI;
			end
			S_W1_HI: if (cnt == 24'h0) begin
				if (two_writes(cur.op)) begin
					// Second cycle: same code, or address and data
					next_pins.we_n = 1'b0;
					next_pins.addr = cur.addr;
					next_dq_out = (cur.op == `FCI_OP_PROG) ?
						cur.data : first_byte(cur);
					next_cnt = 24'(`FCI_PHASE_CYC - 1);
					next_state = S_W2_LO;
				end else if (ends_read(cur.op)) begin
					next_dq_oe = 1'b0;
					next_cnt = 24'(`FCI_RECOV_CYC - 1);
					next_state = S_WAIT;
				end else begin
					next_state = S_DONE;
				end
			end
			S_W2_LO: if (cnt == 24'h0) begin
				next_pins.we_n = 1'b1;
				next_state = S_WAIT;
				// Least pulse time; device stops the pulse itself
				case (cur.op)
					`FCI_OP_ERASE: next_cnt = 24'(ERASE_CYC - 1);
					`FCI_OP_PROG: next_cnt = 24'(`FCI_PROG_CYC - 1);
					default: next_cnt = 24'(`FCI_PHASE_CYC - 1);
				endcase
			end
			S_WAIT: begin
				// Data held one cycle past the rising strobe
				next_dq_oe = 1'b0;
				if (cnt == 24'h0) begin
					if (ends_read(cur.op)) begin
						// Read cycle; address kept from the verify write
						next_pins.oe_n = 1'b0;
						if (cur.op == `FCI_OP_READ || cur.op == `FCI_OP_ID)
							next_pins.addr = cur.addr;
						next_cnt = 24'(`FCI_PHASE_CYC - 1);
						next_state = S_RD;
					end else begin
						next_state = S_DONE;
					end
				end
			end
			S_RD: if (cnt == 24'h0) begin
				next_rsp_data = dq_in;
				next_pins.oe_n = 1'b1;
				next_state = S_DONE;
			end
			S_DONE: begin
				// Bus released together with chip select
				next_pins.cs_n = 1'b1;
				next_dq_oe = 1'b0;
				next_rsp_valid = 1'b1;
				next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			cur <= '0;
			cnt <= 24'h0;
			pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, vpp_high: 1'b0,
				id_high_voltage_address_line: 1'b0, addr: 17'h0};
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
		end else begin
			state <= next_state;
			cur <= next_cur;
			cnt <= next_cnt;
			pins <= next_pins;
			dq_out <= next_dq_out;
			dq_oe <= next_dq_oe;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
		end
	end

	// Checks
	property p_read_pins;
		@(posedge clk) disable iff (!rst_n)
		!pins.oe_n |-> (!pins.cs_n && pins.we_n && !dq_oe);
	endproperty
	a_read_pins: assert property (p_read_pins)
		else $error("read with bad strobes");

	property p_standby_float;
		@(posedge clk) disable iff (!rst_n)
		pins.cs_n |-> !dq_oe;
	endproperty
	a_standby_float: assert property (p_standby_float)
		else $error("bus driven in standby");

	property p_write_supply;
		@(posedge clk) disable iff (!rst_n)
		$fell(pins.we_n) |-> pins.vpp_high && !pins.cs_n && dq_oe;
	endproperty
	a_write_supply: assert property (p_write_supply)
		else $error("write without supply");

	property p_strobe_width;
		@(posedge clk) disable iff (!rst_n)
		$fell(pins.we_n) |-> !pins.we_n [*3];
	endproperty
	a_strobe_width: assert property (p_strobe_width)
		else $error("strobe low too short");

	property p_erase_twice;
		@(posedge clk) disable iff (!rst_n)
		(state == S_W2_LO && cur.op == `FCI_OP_ERASE) |->
			dq_out == `FCI_CMD_ERASE;
	endproperty
	a_erase_twice: assert property (p_erase_twice)
		else $error("second erase byte wrong");

	property p_abort_twice;
		@(posedge clk) disable iff (!rst_n)
		(state == S_W2_LO && cur.op == `FCI_OP_ABORT) |->
			dq_out == `FCI_CMD_RESET;
	endproperty
	a_abort_twice: assert property (p_abort_twice)
		else $error("second reset byte wrong");

	property p_prog_data;
		@(posedge clk) disable iff (!rst_n)
		(state == S_W2_LO && cur.op == `FCI_OP_PROG) |->
			dq_out == cur.data && pins.addr == cur.addr;
	endproperty
	a_prog_data: assert property (p_prog_data)
		else $error("program data wrong");

	property p_prog_wait;
		@(posedge clk) disable iff (!rst_n)
		(state == S_W2_LO && cnt == 24'h0 && cur.op == `FCI_OP_PROG) |=>
			pins.we_n [*8];
	endproperty
	a_prog_wait: assert property (p_prog_wait)
		else $error("program pulse cut short");

	property p_data_hold;
		@(posedge clk) disable iff (!rst_n)
		$rose(pins.we_n) |-> dq_oe && !pins.cs_n;
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("data released at rising strobe");
endmodule

// ---- rtl/fci_defs.svh ----
`ifndef FCI_DEFS_SVH
`define FCI_DEFS_SVH
// How it works
// - With programming supply high, host writes read-select before array reads.
// - Id by high voltage: normal read, id line high, other lines low; host keeps the id line low and reads ids by 90h instead.
// - Host writes 20h twice in a row to start chip erase.
// - Erase-verify every byte after each erase pulse; host writes A0h only on an erase-verify request, not after an erase by itself.
// - Program: write 40h, then a write carrying address and data.
// - Program-verify after every byte program; host writes C0h only on a program-verify request, not after a program by itself.
`define FCI_CMD_READ 8'h00
`define FCI_CMD_ID 8'h90
`define FCI_CMD_ERASE 8'h20
`define FCI_CMD_ERASE_VFY 8'ha0
`define FCI_CMD_PROG 8'h40
`define FCI_CMD_PROG_VFY 8'hc0
`define FCI_CMD_RESET 8'hff
`define FCI_OP_READ 3'h0
`define FCI_OP_ID 3'h1
`define FCI_OP_ERASE 3'h2
`define FCI_OP_ERASE_VFY 3'h3
`define FCI_OP_PROG 3'h4
`define FCI_OP_PROG_VFY 3'h5
`define FCI_OP_ABORT 3'h6
`define FCI_OP_CMD 3'h7
// Strobe phase length, 60 ns each
`define FCI_PHASE_NS 60
`define FCI_CLK_NS 20
`define FCI_PHASE_CYC ((`FCI_PHASE_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
// Program pulse 10 us, erase pulse 9.5 ms, write recovery 6 us
`define FCI_PROG_NS 10000
`define FCI_ERASE_NS 9500000
`define FCI_RECOV_NS 6000
`define FCI_PROG_CYC ((`FCI_PROG_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_ERASE_CYC ((`FCI_ERASE_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_RECOV_CYC ((`FCI_RECOV_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`endif

// ---- rtl/fci_pkg.sv ----
package fci_pkg;
	typedef struct packed {
		logic [2:0] op;
		logic [16:0] addr;
		logic [7:0] data;
	} fci_req_t;
	typedef struct packed {
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic vpp_high;
		logic id_high_voltage_address_line;
		logic [16:0] addr;
	} fci_pins_t;
	typedef enum logic [3:0] {
		S_IDLE, S_W1_LO, S_W1_HI, S_GAP, S_W2_LO, S_W2_HI,
		S_WAIT, S_RD, S_DONE
	} fci_state_t;
endpackage

// ---- bench/fci_flash_model.sv ----
`timescale 1ns/10ps
module fci_flash_model #(
	parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
	parameter logic [7:0] PART = 8'ha6 // Arbitrary value
) (
	// Control pins
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic vpp_high,
	input wire logic [16:0] addr,
	// Data bus
	input wire logic [7:0] dq_out,
	input wire logic dq_oe,
	output logic [7:0] dq_in
);
	logic [7:0] mem [0:15];
	logic [1:0] mode;
	logic [7:0] pend;
	logic [7:0] d;
	logic [16:0] ta;
	logic [16:0] la;
	// Power-up contents, read mode
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 8'h10 + 8'(i);
		mode = 2'h0;
		pend = 8'h00;
		ta = '0;
		la = '0;
		dq_in = 8'h00;
	end
	// Address taken on falling strobe
	// Short settle so select and address updated in the same step are seen
	always @(negedge we_n) #1 if (!cs_n) ta = addr;
	// Command decode on rising strobe
	always @(posedge we_n) begin
		d = dq_oe ? dq_out : 8'h00;
		if (!cs_n && vpp_high) begin
			// FFh after 40h opens an abort instead of programming
			if (pend == 8'h40 && d != 8'hff) begin
				la = ta;
				mem[la[3:0]] = d;
				pend = 8'h00;
			end else if (pend == 8'h20 && d == 8'h20) begin
				for (int i = 0; i < 16; i++) mem[i] = 8'hff;
				pend = 8'h00;
			end else if (pend == 8'hff && d == 8'hff) begin
				mode = 2'h0;
				pend = 8'h00;
			end else begin
				pend = 8'h00;
				case (d)
					8'h00: mode = 2'h0;
					8'h90: mode = 2'h1;
					8'ha0: begin
						la = ta;
						mode = 2'h2;
					end
					8'hc0: mode = 2'h2;
					8'h20, 8'h40, 8'hff: pend = d;
					default: ;
				endcase
			end
		end
	end
	// Read drive, changing pattern while floating
	always @(cs_n or oe_n or we_n or addr or mode) begin
		if (!cs_n && !oe_n && we_n) begin
			if (mode == 2'h1) dq_in = addr[0] ? PART : MAKER;
			else if (mode == 2'h2) dq_in = mem[la[3:0]];
			else dq_in = mem[addr[3:0]];
		end else dq_in = ~dq_in;
	end
endmodule

// ---- bench/tb_fci_host.sv ----
`timescale 1ns/10ps
module tb_fci_host;
	import fci_pkg::*;
	localparam logic [7:0] MAKER = 8'h5a;
	localparam logic [7:0] PART = 8'ha6;
	logic clk, rst_n, req_valid, req_ready, rsp_valid, dq_oe;
	fci_req_t req;
	fci_pins_t pins;
	logic [7:0] rsp_data, dq_in, dq_out, rd;
	int fail_count, check_count;
	int cyc = 0;
	fci_host #(.ERASE_CYC(10)) i_fci_host (.clk(clk), .rst_n(rst_n),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	fci_flash_model #(.MAKER(MAKER), .PART(PART)) i_fci_flash_model (
		.cs_n(pins.cs_n), .oe_n(pins.oe_n), .we_n(pins.we_n),
		.vpp_high(pins.vpp_high), .addr(pins.addr), .dq_out(dq_out),
		.dq_oe(dq_oe), .dq_in(dq_in));
	// Clock
	initial clk = 1'b0;
	always #10 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic finish_test;
		$display("checks=%0d fails=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One request, wait for its answer
	task automatic do_op(input logic [2:0] op, input logic [16:0] a,
		input logic [7:0] dt);
		for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clk);
		chk8({7'h0, req_ready}, 8'h01);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= {op, a, dt};
		@(posedge clk);
		req_valid <= 1'b0;
		for (int i = 0; i < 2000; i++) begin
			@(negedge clk);
			if (rsp_valid === 1'b1) break;
		end
		chk8({7'h0, rsp_valid}, 8'h01);
		rd = rsp_data;
	endtask
	task automatic t_power_up;
		chk8({7'h0, pins.cs_n}, 8'h01);
		chk8({7'h0, dq_oe}, 8'h00);
		do_op(3'h0, 17'h00003, 8'h00);
		chk8(rd, 8'h13);
		do_op(3'h0, 17'h1000c, 8'h00);
		chk8(rd, 8'h1c);
	endtask
	task automatic t_ident;
		do_op(3'h1, 17'h00000, 8'h00);
		chk8(rd, MAKER);
		do_op(3'h1, 17'h00001, 8'h00);
		chk8(rd, PART);
		do_op(3'h0, 17'h00001, 8'h00);
		chk8(rd, 8'h11);
	endtask
	task automatic t_program;
		do_op(3'h4, 17'h00006, 8'h3c);
		do_op(3'h5, 17'h00006, 8'h00);
		chk8(rd, 8'h3c);
		do_op(3'h0, 17'h00006, 8'h00);
		chk8(rd, 8'h3c);
	endtask
	// Abort pending program second cycle
	task automatic t_abort;
		do_op(3'h4, 17'h00009, 8'h55);
		do_op(3'h5, 17'h00009, 8'h00);
		chk8(rd, 8'h55);
		do_op(3'h7, 17'h00009, 8'h40);
		do_op(3'h6, 17'h00009, 8'h00);
		do_op(3'h0, 17'h00009, 8'h00);
		chk8(rd, 8'h55);
	endtask
	task automatic t_erase;
		do_op(3'h2, 17'h00000, 8'h00);
		for (int i = 0; i < 16; i++) begin
			do_op(3'h3, 17'(i), 8'h00);
			chk8(rd, 8'hff);
		end
		do_op(3'h0, 17'h00006, 8'h00);
		chk8(rd, 8'hff);
	endtask
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		fail_count = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		t_power_up();
		t_ident();
		t_program();
		t_abort();
		t_erase();
		finish_test();
	end
endmodule
